// ==== design/wdc_pkg.sv ====
package wdc_pkg;
  // ****************************************************************
  // Register map, byte addresses on the AXI4-Lite bus.
  // ****************************************************************
  localparam logic [7:0] WDC_CS1_OFF = 8'h00;    // Control and status one.
  localparam logic [7:0] WDC_CNTH_OFF = 8'h04;   // Counter high byte, unlock writes.
  localparam logic [7:0] WDC_CNTL_OFF = 8'h08;   // Counter low byte, read only.
  localparam logic [7:0] WDC_TOVH_OFF = 8'h0c;   // Timeout high byte.
  localparam logic [7:0] WDC_TOVL_OFF = 8'h10;   // Timeout low byte.
  localparam logic [7:0] WDC_STAT_OFF = 8'h14;   // Sticky event status.
  localparam logic [7:0] WDC_MASK_OFF = 8'h18;   // Interrupt mask.

  // ****************************************************************
  // Field positions of control and status one.
  // ****************************************************************
  localparam int WDC_EN_BIT = 7;
  localparam int WDC_INT_BIT = 6;
  localparam int WDC_UPD_BIT = 5;
  localparam int WDC_FAST_HI = 4;
  localparam int WDC_FAST_LO = 3;
  localparam int WDC_DEBUG_BIT = 2;
  localparam int WDC_WAIT_BIT = 1;
  localparam int WDC_STOP_BIT = 0;

  // Reset values; the test field itself is held apart from this value.
  localparam logic [7:0] WDC_CS1_RST = 8'h80;
  localparam logic [7:0] WDC_TOVH_RST = 8'h09;
  localparam logic [7:0] WDC_TOVL_RST = 8'hc4;

  // Test field codes.
  localparam logic [1:0] WDC_FAST_NONE = 2'h0;
  localparam logic [1:0] WDC_FAST_USER = 2'h1;
  localparam logic [1:0] WDC_FAST_LOW = 2'h2;
  localparam logic [1:0] WDC_FAST_HIGH = 2'h3;

  // Unlock words.
  localparam logic [15:0] WDC_UNLOCK1 = 16'hc520;
  localparam logic [15:0] WDC_UNLOCK2 = 16'hd928;

  // ****************************************************************
  // Timing at the 200 MHz bus clock.
  // ****************************************************************
  localparam int WDC_CLK_PS = 5000;
  localparam int WDC_RST_DELAY_CLKS = 128;   // Reset hold-off, bus clocks.
  localparam int WDC_UPD_WIN_CLKS = 128;     // Update window, bus clocks.
  localparam int WDC_UNLOCK_GAP_CLKS = 16;   // Greatest gap between unlock words.

  // Status bits: 0 timeout with interrupt select, 1 delayed reset issued.
  localparam int WDC_EVT_W = 2;

  typedef enum logic [1:0] {
    WDC_RUN = 2'b00,
    WDC_HOLD = 2'b01,
    WDC_FIRE = 2'b10
  } wdc_state_type;
endpackage : wdc_pkg

// ==== design/wdc_down_counter.sv ====
`timescale 1ns/1ps
// Loadable down counter; done is high while the count rests at zero.
module wdc_down_counter #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  output logic [W-1:0] count,
  output logic done
);
  // Counts down to zero and stays there until loaded again.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count <= '0;
    end else if (load) begin
      count <= loadValue;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign done = (count == '0);
endmodule : wdc_down_counter

// ==== design/wdc_control.sv ====
`timescale 1ns/1ps
//Contract
// [R1] Interrupt select clear: no interrupt, immediate reset.
// [R2] Interrupt select set: interrupt, reset 128 clocks later.
// [R3] Update bit clear: configuration locked after setup.
// [R4] Update bit set: writes accepted 128 clocks after unlock.
// [R5] Test field cleared only by power-on reset.
// [R6] Codes 00 and 01 leave test mode off.
// [R7] Low test code compares low bytes only.
// [R8] Code 11 compares high bytes only.
// [R9] Software writes user code after testing.
// [R10] Debug bit keeps watchdog running in debug.
// [R11] Wait bit keeps watchdog running in wait.
// [R12] Stop bit keeps watchdog running in stop.
// [R13] Configuration bits write once, then only unlocked.
// [R14] Enable bit starts the counter counting.
// [R15] Unlock words follow within 16 clocks.
// [R16] Window end locks configuration again.
module wdc_control (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic porN,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Chip mode inputs and counter link.
  input wire logic debugMode,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic [15:0] counterValue,
  input wire logic resetTrigger,
  output logic counterRun,
  output logic timeoutMatch,
  output logic wdogIrq,
  output logic wdogReset,
  output logic irqOut
);
  import wdc_pkg::*;

  // ****************************************************************
  // Configuration state.
  // ****************************************************************
  logic [7:0] cs1Reg;           // Control bits other than the test field.
  logic [1:0] fastCheckReg;     // Test field, kept across warm resets.
  logic writtenReg;             // First control and status one write has happened.
  logic [15:0] tovReg;          // Timeout value.
  logic [WDC_EVT_W-1:0] statusReg;  // Sticky events.
  logic [WDC_EVT_W-1:0] maskReg;    // Interrupt mask.
  logic [7:0] gapCntReg;        // Clocks since the first unlock word.
  logic gapOpenReg;             // First unlock word seen.
  wdc_state_type stateReg;      // Reset sequencing state.

  // Window and hold counter instance signals.
  logic winLoad;
  logic [7:0] winCount;
  logic winDone;
  logic holdLoad;
  logic [7:0] holdCount;
  logic holdDone;

  // ****************************************************************
  // AXI4-Lite handshakes.
  // ****************************************************************
  logic awHeldReg;
  logic wHeldReg;
  logic [7:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic doWrite;

  // Address and data may arrive in either order; each is latched once.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      awHeldReg <= 1'b0;
      wHeldReg <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
    end else if (doWrite) begin
      awHeldReg <= 1'b0;
      wHeldReg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldReg <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
    end
  end

  // Address ready is a flop so the port has no path from the response logic.
  // It drops on its handshake edge and returns once the response is taken.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeldReg && !s_axi_bvalid && !doWrite;
    end
  end

  // Data ready follows the same pattern as the address side.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wHeldReg && !s_axi_bvalid && !doWrite;
    end
  end

  // The write takes effect the cycle after both halves are held.
  assign doWrite = awHeldReg && wHeldReg && !s_axi_bvalid;

  // The write response; unmapped addresses answer with DECERR.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addrKnown(awAddrReg) ? 2'b00 : 2'b11;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Tells whether an address falls on one of the registers.
  function automatic logic addrKnown(input logic [7:0] a);
    addrKnown = (a == WDC_CS1_OFF) || (a == WDC_CNTH_OFF) || (a == WDC_CNTL_OFF) ||
                (a == WDC_TOVH_OFF) || (a == WDC_TOVL_OFF) || (a == WDC_STAT_OFF) ||
                (a == WDC_MASK_OFF);
  endfunction : addrKnown

  // ****************************************************************
  // Unlock sequence and update window.
  // ****************************************************************
  logic cntWrite;
  logic [15:0] cntWord;
  logic unlockDone;
  logic winOpen;
  logic cfgWritable;

  // Counter writes carry the unlock words; a full word goes to the high offset.
  assign cntWrite = doWrite && (awAddrReg == WDC_CNTH_OFF);
  assign cntWord = wDataReg[15:0];
  assign unlockDone = cntWrite && gapOpenReg && (cntWord == WDC_UNLOCK2) && cs1Reg[WDC_UPD_BIT]; // [R4]

  // The second word counts only within the gap after the first.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gapOpenReg <= 1'b0;
      gapCntReg <= 8'h00;
    end else if (cntWrite) begin
      gapOpenReg <= (cntWord == WDC_UNLOCK1);
      gapCntReg <= 8'h00;
    end else if (gapOpenReg) begin
      gapCntReg <= gapCntReg + 8'h01;
      if (gapCntReg >= 8'(WDC_UNLOCK_GAP_CLKS - 1)) begin
        gapOpenReg <= 1'b0; // [R15]
      end
    end
  end

  // The window counter runs for 128 clocks after an unlock.
  assign winLoad = unlockDone;
  wdc_down_counter #(.W(8)) u_window (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(winLoad),
    .loadValue(8'(WDC_UPD_WIN_CLKS)),
    .count(winCount),
    .done(winDone)
  );
  assign winOpen = !winDone; // [R16]

  // Writable once after reset, then only inside an unlock window.
  assign cfgWritable = !writtenReg || winOpen; // [R3] [R13]

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic cs1Write;
  assign cs1Write = doWrite && (awAddrReg == WDC_CS1_OFF) && wStrbReg[0];

  // Control bits; writes outside the allowed time are dropped silently.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cs1Reg <= WDC_CS1_RST;
      writtenReg <= 1'b0;
    end else if (cs1Write && cfgWritable) begin
      cs1Reg <= wDataReg[7:0]; // [R13]
      writtenReg <= 1'b1;
    end
  end

  // The test field answers only to power-on reset, not to nrst.
  always_ff @(posedge sys_clk) begin
    if (!porN) begin
      fastCheckReg <= WDC_FAST_NONE; // [R5]
    end else if (cs1Write && cfgWritable) begin
      fastCheckReg <= wDataReg[WDC_FAST_HI:WDC_FAST_LO];
    end
  end

  // Timeout value, under the same write-once guard.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tovReg <= {WDC_TOVH_RST, WDC_TOVL_RST};
    end else if (doWrite && cfgWritable && wStrbReg[0]) begin
      if (awAddrReg == WDC_TOVH_OFF) begin
        tovReg[15:8] <= wDataReg[7:0];
      end
      if (awAddrReg == WDC_TOVL_OFF) begin
        tovReg[7:0] <= wDataReg[7:0];
      end
    end
  end

  // ****************************************************************
  // Counter gating and compare.
  // ****************************************************************
  // Runs only if enabled and permitted in the current chip mode.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      counterRun <= 1'b0;
    end else begin
      counterRun <= cs1Reg[WDC_EN_BIT] && // [R14]
                    (!debugMode || cs1Reg[WDC_DEBUG_BIT]) && // [R10]
                    (!waitMode || cs1Reg[WDC_WAIT_BIT]) && // [R11]
                    (!stopMode || cs1Reg[WDC_STOP_BIT]); // [R12]
    end
  end

  // Byte selection by test code; user and off codes compare the full word.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      timeoutMatch <= 1'b0;
    end else begin
      unique case (fastCheckReg)
        WDC_FAST_LOW: timeoutMatch <= counterValue[7:0] == tovReg[7:0]; // [R7]
        WDC_FAST_HIGH: timeoutMatch <= counterValue[15:8] == tovReg[15:8]; // [R8]
        WDC_FAST_NONE, WDC_FAST_USER: timeoutMatch <= counterValue == tovReg; // [R6]
      endcase
    end
  end

  // ****************************************************************
  // Reset sequencing.
  // ****************************************************************
  assign holdLoad = (stateReg == WDC_RUN) && resetTrigger && cs1Reg[WDC_INT_BIT];
  wdc_down_counter #(.W(8)) u_hold (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(holdLoad),
    .loadValue(8'(WDC_RST_DELAY_CLKS - 1)),
    .count(holdCount),
    .done(holdDone)
  );

  // A trigger either resets at once or first raises the interrupt.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stateReg <= WDC_RUN;
      wdogIrq <= 1'b0;
      wdogReset <= 1'b0;
    end else begin
      unique case (stateReg)
        WDC_RUN: begin
          if (resetTrigger && cs1Reg[WDC_INT_BIT]) begin
            stateReg <= WDC_HOLD;
            wdogIrq <= 1'b1; // [R2]
          end else if (resetTrigger) begin
            stateReg <= WDC_FIRE;
            wdogReset <= 1'b1; // [R1]
          end
        end
        WDC_HOLD: begin
          if (holdDone) begin
            stateReg <= WDC_FIRE;
            wdogReset <= 1'b1; // [R2]
          end
        end
        WDC_FIRE: begin
          wdogReset <= 1'b1;
        end
        default: begin
          stateReg <= WDC_RUN;
        end
      endcase
    end
  end

  // ****************************************************************
  // Status, mask and interrupt output.
  // ****************************************************************
  logic [WDC_EVT_W-1:0] evt;
  assign evt = {(stateReg != WDC_FIRE) && (stateReg == WDC_HOLD) && holdDone,
                holdLoad};

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      statusReg <= '0;
    end else begin
      if (doWrite && (awAddrReg == WDC_STAT_OFF) && wStrbReg[0]) begin
        statusReg <= (statusReg & ~wDataReg[WDC_EVT_W-1:0]) | evt;
      end else begin
        statusReg <= statusReg | evt;
      end
    end
  end

  // Mask register is a plain read-write word.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      maskReg <= '0;
    end else if (doWrite && (awAddrReg == WDC_MASK_OFF) && wStrbReg[0]) begin
      maskReg <= wDataReg[WDC_EVT_W-1:0];
    end
  end

  // The level output follows one cycle behind the status bits.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(statusReg & maskReg);
    end
  end

  // ****************************************************************
  // Read channel.
  // ****************************************************************
  // Answers one cycle after the address is taken.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && !s_axi_arready) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addrKnown(s_axi_araddr) ? 2'b00 : 2'b11;
      unique case (s_axi_araddr)
        WDC_CS1_OFF: s_axi_rdata <= {24'h0, cs1Reg[7:5], fastCheckReg, cs1Reg[2:0]};
        WDC_CNTH_OFF: s_axi_rdata <= {24'h0, counterValue[15:8]};
        WDC_CNTL_OFF: s_axi_rdata <= {24'h0, counterValue[7:0]};
        WDC_TOVH_OFF: s_axi_rdata <= {24'h0, tovReg[15:8]};
        WDC_TOVL_OFF: s_axi_rdata <= {24'h0, tovReg[7:0]};
        WDC_STAT_OFF: s_axi_rdata <= {30'h0, statusReg};
        WDC_MASK_OFF: s_axi_rdata <= {30'h0, maskReg};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  AST_IMMEDIATE_RESET: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
    (stateReg == WDC_RUN && resetTrigger && !cs1Reg[WDC_INT_BIT]) |=> wdogReset && !wdogIrq)
    else $error("Reset not immediate with interrupt select clear.");
  AST_DELAYED_RESET: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
    (stateReg == WDC_RUN && resetTrigger && cs1Reg[WDC_INT_BIT]) |=>
      wdogIrq && !wdogReset ##127 !wdogReset ##1 wdogReset)
    else $error("Reset not delayed by 128 clocks.");
  AST_LOCKED: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
    (cs1Write && writtenReg && winDone) |=> $stable(cs1Reg))
    else $error("Locked configuration changed.");
  AST_WINDOW: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
    unlockDone |=> winOpen [*8])
    else $error("Update window not open after unlock.");
  AST_WINDOW_END: assert property (@(posedge sys_clk) disable iff (!nrst) // [R16]
    unlockDone |=> ##128 !winOpen)
    else $error("Update window did not close.");
  AST_LOW_BYTE: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
    (fastCheckReg == WDC_FAST_LOW && $stable(fastCheckReg) && counterValue[7:0] == tovReg[7:0]
     && $stable(tovReg)) |=> timeoutMatch)
    else $error("Low byte compare missed.");
  AST_HIGH_BYTE: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
    (fastCheckReg == WDC_FAST_HIGH && counterValue[15:8] != tovReg[15:8] && $stable(tovReg))
    |=> !timeoutMatch)
    else $error("High byte compare wrong.");
  AST_DEBUG_GATE: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
    (debugMode && !cs1Reg[WDC_DEBUG_BIT]) |=> !counterRun)
    else $error("Counter ran in debug with bit clear.");
  AST_STOP_GATE: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
    (stopMode && !cs1Reg[WDC_STOP_BIT]) |=> !counterRun)
    else $error("Counter ran in stop with bit clear.");
  AST_ONCE: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
    (cs1Write && !writtenReg) |=> writtenReg && cs1Reg[WDC_EN_BIT] == $past(wDataReg[7]))
    else $error("First write not taken.");
endmodule : wdc_control

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  import wdc_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic porN = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic debugMode = 1'b0, waitMode = 1'b0, stopMode = 1'b0, resetTrigger = 1'b0;
  logic [15:0] counterValue = 16'h0000;
  logic counterRun, timeoutMatch, wdogIrq, wdogReset, irqOut;
  int nMismatch = 0;
  int numChecks = 0;
  int cycles = 0;
  int n;

  // The device under test, every input driven by the bench.
  wdc_control u_dut (.sys_clk(sys_clk), .nrst(nrst), .porN(porN),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .debugMode(debugMode),
    .waitMode(waitMode), .stopMode(stopMode), .counterValue(counterValue),
    .resetTrigger(resetTrigger), .counterRun(counterRun), .timeoutMatch(timeoutMatch),
    .wdogIrq(wdogIrq), .wdogReset(wdogReset), .irqOut(irqOut));

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // A hung handshake must not stall the run forever.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nMismatch++;
      summarize();
    end
  end

  // ****************************************************************
  // Bus and compare tasks.
  // ****************************************************************
  // Verdict and end of run; the only place the run stops.
  task summarize();
    if (nMismatch == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // Four-state compare so that an unknown never passes.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Address and data offered together; each dropped on its own handshake edge.
  task axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axiWrite

  // Read address held until taken; rready held until the answer.
  task axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axiRead

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
  endtask : wr

  task rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    check(d, e);
  endtask : rdChk

  // Registered outputs are looked at once they have settled.
  task modeChk(input logic d, input logic w, input logic s, input logic e);
    @(posedge sys_clk);
    debugMode <= d;
    waitMode <= w;
    stopMode <= s;
    repeat (3) @(posedge sys_clk);
    #1 check(counterRun, e);
  endtask : modeChk

  task cvChk(input logic [15:0] v, input logic e);
    @(posedge sys_clk);
    counterValue <= v;
    repeat (3) @(posedge sys_clk);
    #1 check(timeoutMatch, e);
  endtask : cvChk

  // One-cycle trigger; n counts cycles from the irq edge to the reset request.
  task pulseTrig(input logic irqExp);
    @(posedge sys_clk);
    resetTrigger <= 1'b1;
    @(posedge sys_clk);
    resetTrigger <= 1'b0;
    #1 check(wdogIrq, irqExp);
    n = 0;
    while (wdogReset !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask : pulseTrig

  task unlock();
    wr(WDC_CNTH_OFF, {16'h0000, WDC_UNLOCK1});
    wr(WDC_CNTH_OFF, {16'h0000, WDC_UNLOCK2});
  endtask : unlock

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    porN <= 1'b1;
    rdChk(WDC_CS1_OFF, 32'h00000080);
    rdChk(WDC_TOVH_OFF, 32'h00000009);
    rdChk(WDC_TOVL_OFF, 32'h000000c4);
    modeChk(1'b0, 1'b0, 1'b0, 1'b1);
    // Unmapped places answer with a decode error.
    axiRead(8'h40, d, r);
    check({30'h0, r}, 32'h00000003);
    axiWrite(8'h40, 32'h000000ff, r);
    check({30'h0, r}, 32'h00000003);
    // First setup: update allowed, high-byte test, debug run only.
    wr(WDC_TOVH_OFF, 32'h00000012);
    wr(WDC_TOVL_OFF, 32'h00000034);
    wr(WDC_CS1_OFF, 32'h000000bc);
    rdChk(WDC_CS1_OFF, 32'h000000bc);
    wr(WDC_CS1_OFF, 32'h00000000);
    rdChk(WDC_CS1_OFF, 32'h000000bc);
    wr(WDC_TOVH_OFF, 32'h00000055);
    rdChk(WDC_TOVH_OFF, 32'h00000012);
    modeChk(1'b1, 1'b0, 1'b0, 1'b1);
    modeChk(1'b0, 1'b1, 1'b0, 1'b0);
    modeChk(1'b0, 1'b0, 1'b1, 1'b0);
    cvChk(16'h12ff, 1'b1);
    cvChk(16'h1334, 1'b0);
    // Unlocked rewrite: interrupt select, low-byte test, wait and stop run.
    unlock();
    wr(WDC_CS1_OFF, 32'h000000d3);
    rdChk(WDC_CS1_OFF, 32'h000000d3);
    modeChk(1'b1, 1'b0, 1'b0, 1'b0);
    modeChk(1'b0, 1'b1, 1'b1, 1'b1);
    cvChk(16'hff34, 1'b1);
    cvChk(16'h3412, 1'b0);
    // Window expiry, then an unlock with updates now forbidden.
    repeat (WDC_UPD_WIN_CLKS + 4) @(posedge sys_clk);
    wr(WDC_CS1_OFF, 32'h000000bc);
    rdChk(WDC_CS1_OFF, 32'h000000d3);
    unlock();
    wr(WDC_CS1_OFF, 32'h000000bc);
    rdChk(WDC_CS1_OFF, 32'h000000d3);
    // Interrupt first, reset held off; then status, mask and clear.
    pulseTrig(1'b1);
    check(n, WDC_RST_DELAY_CLKS);
    rdChk(WDC_STAT_OFF, 32'h00000003);
    #1 check(irqOut, 1'b0);
    wr(WDC_MASK_OFF, 32'h00000001);
    repeat (2) @(posedge sys_clk);
    #1 check(irqOut, 1'b1);
    wr(WDC_STAT_OFF, 32'h00000001);
    rdChk(WDC_STAT_OFF, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    #1 check(irqOut, 1'b0);
    // Plain reset keeps the test field.
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    rdChk(WDC_CS1_OFF, 32'h00000090);
    #1 check(wdogReset, 1'b0);
    // User code: full compare, immediate reset without interrupt.
    wr(WDC_CS1_OFF, 32'h00000088);
    rdChk(WDC_CS1_OFF, 32'h00000088);
    cvChk(16'h09c4, 1'b1);
    cvChk(16'h08c4, 1'b0);
    pulseTrig(1'b0);
    check(n, 0);
    // Power-on reset clears the test field; enable clear stops the counter.
    @(posedge sys_clk);
    nrst <= 1'b0;
    porN <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    porN <= 1'b1;
    rdChk(WDC_CS1_OFF, 32'h00000080);
    wr(WDC_CS1_OFF, 32'h00000007);
    rdChk(WDC_CS1_OFF, 32'h00000007);
    modeChk(1'b0, 1'b0, 1'b0, 1'b0);
    cvChk(16'h09c4, 1'b1);
    cvChk(16'h19c4, 1'b0);
    summarize();
  end
endmodule : tb
